// File: hdl/lts_sequencer.sv
// Layered trigger sequencer with event sources, output routing and data buffer
`timescale 1ns/10ps
`include "lts_cfg.svh"

module lts_sequencer (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire lts_pkg::lts_wr_t i_det_wr,
  input  wire lts_pkg::lts_wr_t i_main_wr,
  input  wire logic            i_continuous,
  input  wire logic [1:0]      i_initiate,
  input  wire logic [1:0]      i_abort,
  input  wire logic [1:0]      i_bus_trig,
  input  wire logic [1:0]      i_act_done,
  input  wire logic [1:0]      i_internal_bus,
  input  wire logic            i_lan_evt,
  input  wire logic [6:0]      i_dio_in,
  input  wire logic            i_trigger_in_input,
  input  wire logic            i_meas_valid,
  input  wire logic [31:0]     i_meas_data,
  input  wire logic [16:0]     i_buf_raddr,
  output logic [1:0]           o_internal_bus,
  output logic                 o_lan_trig,
  output logic [6:0]           o_dio_out,
  output logic [6:0]           o_dio_oe,
  output logic                 o_trigger_out_output,
  output logic [1:0]           o_act_run,
  output logic [1:0]           o_busy,
  output logic [16:0]          o_buf_count,
  output logic [31:0]          o_buf_rdata
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [36:0] eff_period(input logic [36:0] p);
    eff_period = (p < `LTS_PER_MIN_US) ? `LTS_PER_MIN_US : p;
  endfunction : eff_period

  function automatic logic [10:0] route_vec(input lts_pkg::lts_ocfg_t c);
    logic [10:0] v;
    v = 11'h000;
    case (c.route)
      lts_pkg::LTS_OT_INTERNAL_BUS_ONE: v[0] = 1'b1;
      lts_pkg::LTS_OT_INTERNAL_BUS_TWO: v[1] = 1'b1;
      lts_pkg::LTS_OT_LAN:  v[2] = 1'b1;
      lts_pkg::LTS_OT_DIO:  if (c.pin != 3'h0) v[`LTS_OT_DIO_BASE + {1'b0, c.pin} - 4'h1] = 1'b1;
      lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT: v[`LTS_OT_TRIGGER_OUT_OUTPUT_BIT] = 1'b1;
      default:              v = 11'h000;
    endcase
    route_vec = v;
  endfunction : route_vec

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [10:0] pin_s1_reg;
  logic [10:0] pin_s2_reg;
  logic [10:0] pin_s3_reg;
  wire  [10:0] pin_edge = pin_s2_reg & ~pin_s3_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_reg <= 11'h000;
      pin_s2_reg <= 11'h000;
      pin_s3_reg <= 11'h000;
    end else begin
      pin_s1_reg <= {i_trigger_in_input, i_dio_in, i_lan_evt, i_internal_bus};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Microsecond tick drives timer and delay
  logic [7:0] tick_cnt_reg;
  wire        tick = (tick_cnt_reg == 8'(`LTS_TICK_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) tick_cnt_reg <= 8'h00;
    else tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
  end

  // ************************************************************
  // Settings store
  // ************************************************************
  lts_pkg::lts_lcfg_t lcfg_reg [2][2];
  lts_pkg::lts_ocfg_t ocfg_reg [2][3];
  logic               lock_reg [2][2];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int a = 0; a < 2; a++) begin
        for (int l = 0; l < 3; l++) begin
          ocfg_reg[a][l] <= '{en: 1'b0, route: lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT, pin: 3'h1};
          if (l < 2) begin
            lcfg_reg[a][l] <= '{count: `LTS_RST_COUNT, inf: 1'b0, bypass: 1'b0, src: lts_pkg::LTS_SRC_AUTO,
                                period_us: `LTS_RST_PERIOD, delay_us: `LTS_RST_DELAY};
            lock_reg[a][l] <= 1'b0;
          end
        end
      end
    end else begin
      for (int a = 0; a < 2; a++) begin
        for (int l = 0; l < 3; l++) begin
          // Main view wins in the same cycle and locks out later detailed writes to the layer settings; output settings stay writable
          if (i_main_wr.we && i_main_wr.layer == l && i_main_wr.action == a) begin
            ocfg_reg[a][l] <= i_main_wr.ocfg;
            if (l < 2) begin
              lcfg_reg[a][l] <= i_main_wr.lcfg;
              lock_reg[a][l] <= 1'b1;
            end
          end else if (i_det_wr.we && i_det_wr.layer == l && i_det_wr.action == a) begin
            ocfg_reg[a][l] <= i_det_wr.ocfg;
            if (l < 2 && !lock_reg[a][l]) lcfg_reg[a][l] <= i_det_wr.lcfg;
          end
        end
      end
    end
  end

  // ************************************************************
  // Per-action layer sequencers
  // ************************************************************
  logic [2:0] fire_w [2];
  logic [1:0] run_w;

  for (genvar a = 0; a < 2; a++) begin : g_act
    lts_pkg::lts_state_t st_reg;
    logic                lyr_reg;
    logic [16:0]         pass_reg [2];
    logic [1:0]          first_reg;
    logic [36:0]         tmr_reg;
    logic [36:0]         dly_reg;

    lts_pkg::lts_lcfg_t cur;
    assign cur = lcfg_reg[a][lyr_reg];

    wire        waiting  = (st_reg == lts_pkg::LTS_ST_WAIT);
    wire        tmr_hit  = waiting && tick && (tmr_reg + 37'h1 >= eff_period(cur.period_us));
    wire        auto_evt = i_continuous ? tmr_hit : 1'b1;
    wire [15:0] ev_vec   = {2'b00, pin_edge[10:2], pin_edge[1:0], tmr_hit, i_bus_trig[a], auto_evt};
    wire        pass_ok  = (first_reg[lyr_reg] && cur.bypass) || ev_vec[cur.src];
    // Tick is free-running, so a nonzero delay waits one extra tick and is never short
    wire        dly_done = (st_reg == lts_pkg::LTS_ST_DELAY)
                           && (cur.delay_us == 37'h0 || dly_reg > cur.delay_us);
    wire        last_arm = !lcfg_reg[a][0].inf && (pass_reg[0] + 17'h1 >= lcfg_reg[a][0].count);
    wire        last_trg = !lcfg_reg[a][1].inf && (pass_reg[1] + 17'h1 >= lcfg_reg[a][1].count);

    assign fire_w[a] = {dly_done && lyr_reg, dly_done && lyr_reg, dly_done && !lyr_reg};
    assign run_w[a]  = dly_done && lyr_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        st_reg      <= lts_pkg::LTS_ST_IDLE;
        lyr_reg     <= 1'b0;
        pass_reg[0] <= 17'h00000;
        pass_reg[1] <= 17'h00000;
        first_reg   <= 2'b11;
        tmr_reg     <= 37'h0;
        dly_reg     <= 37'h0;
      end else if (i_abort[a]) begin
        st_reg <= lts_pkg::LTS_ST_IDLE;
      end else begin
        case (st_reg)
          lts_pkg::LTS_ST_IDLE: begin
            if (i_initiate[a]) begin
              st_reg      <= lts_pkg::LTS_ST_WAIT;
              lyr_reg     <= 1'b0;
              pass_reg[0] <= 17'h00000;
              first_reg   <= 2'b11;
              tmr_reg     <= 37'h0;
            end
          end
          lts_pkg::LTS_ST_WAIT: begin
            if (tick) tmr_reg <= tmr_hit ? 37'h0 : tmr_reg + 37'h1;
            if (pass_ok) begin
              first_reg[lyr_reg] <= 1'b0;
              st_reg             <= lts_pkg::LTS_ST_DELAY;
              dly_reg            <= 37'h0;
            end
          end
          lts_pkg::LTS_ST_DELAY: begin
            if (tick) dly_reg <= dly_reg + 37'h1;
            if (dly_done) begin
              tmr_reg <= 37'h0;
              if (lyr_reg) begin
                st_reg <= lts_pkg::LTS_ST_RUN;
              end else begin
                lyr_reg     <= 1'b1;
                pass_reg[1] <= 17'h00000;
                st_reg      <= lts_pkg::LTS_ST_WAIT;
              end
            end
          end
          lts_pkg::LTS_ST_RUN: begin
            if (i_act_done[a]) begin
              st_reg <= lts_pkg::LTS_ST_WAIT;
              if (last_trg) begin
                lyr_reg     <= 1'b0;
                pass_reg[0] <= pass_reg[0] + 17'h1;
                if (last_arm) st_reg <= lts_pkg::LTS_ST_IDLE;
              end else begin
                pass_reg[1] <= pass_reg[1] + 17'h1;
              end
            end
          end
          default: st_reg <= lts_pkg::LTS_ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Output trigger routing
  // ************************************************************
  logic [10:0] ot_next;
  logic [6:0]  oe_next;

  always_comb begin
    logic [10:0] rv;
    rv      = 11'h000;
    ot_next = 11'h000;
    oe_next = 7'h00;
    for (int a = 0; a < 2; a++) begin
      for (int l = 0; l < 3; l++) begin
        rv = route_vec(ocfg_reg[a][l]);
        if (ocfg_reg[a][l].en) begin
          oe_next = oe_next | rv[9:3];
          if (fire_w[a][l]) ot_next = ot_next | rv;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_internal_bus       <= 2'h0;
      o_lan_trig           <= 1'b0;
      o_dio_out            <= 7'h00;
      o_dio_oe             <= 7'h00;
      o_trigger_out_output <= 1'b0;
      o_act_run            <= 2'h0;
      o_busy               <= 2'h0;
    end else begin
      o_internal_bus       <= ot_next[1:0];
      o_lan_trig           <= ot_next[2];
      o_dio_out            <= ot_next[9:3];
      o_dio_oe             <= oe_next;
      o_trigger_out_output <= ot_next[10];
      o_act_run            <= run_w;
      o_busy               <= {g_act[1].st_reg != lts_pkg::LTS_ST_IDLE, g_act[0].st_reg != lts_pkg::LTS_ST_IDLE};
    end
  end

  // ************************************************************
  // Measurement data buffer
  // ************************************************************
  // Continuous mode wraps, so only the most recent entries survive
  logic [31:0] buf_mem [`LTS_BUF_ONE];
  logic [16:0] wptr_reg;
  wire         buf_wr = i_meas_valid && (i_continuous || o_buf_count < `LTS_BUF_ONE);

  always_ff @(posedge i_clk) begin
    if (buf_wr) buf_mem[wptr_reg] <= i_meas_data;
    o_buf_rdata <= buf_mem[i_buf_raddr];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_reg    <= 17'h00000;
      o_buf_count <= 17'h00000;
    end else if (i_initiate[lts_pkg::LTS_AC_ACQ] && !o_busy[lts_pkg::LTS_AC_ACQ]) begin
      wptr_reg    <= 17'h00000;
      o_buf_count <= 17'h00000;
    end else if (buf_wr) begin
      if (i_continuous) begin
        wptr_reg    <= (wptr_reg + 17'h1 >= `LTS_BUF_CONT) ? 17'h00000 : wptr_reg + 17'h1;
        o_buf_count <= (o_buf_count >= `LTS_BUF_CONT) ? `LTS_BUF_CONT : o_buf_count + 17'h1;
      end else begin
        wptr_reg    <= wptr_reg + 17'h1;
        o_buf_count <= o_buf_count + 17'h1;
      end
    end
  end

endmodule : lts_sequencer

// File: include/lts_cfg.svh
// Constants of the layered trigger sequencer
`ifndef LTS_CFG_SVH
`define LTS_CFG_SVH

`define LTS_CLK_NS       5
`define LTS_TICK_US      1
`define LTS_TICK_CYC     ((`LTS_TICK_US * 1000) / `LTS_CLK_NS)
`define LTS_PER_MIN_US   37'h0_0000_000A
`define LTS_CNT_MAX      17'h186A0
`define LTS_BUF_ONE      17'h186A0
`define LTS_BUF_CONT     17'h003E8
`define LTS_RST_COUNT    17'h00001
`define LTS_RST_PERIOD   37'h0_0000_000A
`define LTS_RST_DELAY    37'h0_0000_0000
`define LTS_OT_DIO_BASE  4'h3
`define LTS_OT_TRIGGER_OUT_OUTPUT_BIT  4'hA

`endif

// File: include/lts_pkg.sv
// Types of the layered trigger sequencer
package lts_pkg;

  typedef enum logic [1:0] {LTS_LY_ARM, LTS_LY_TRIG, LTS_LY_ACT} lts_layer_t;
  typedef enum logic {LTS_AC_TRAN, LTS_AC_ACQ} lts_action_t;
  typedef enum logic [3:0] {
    LTS_SRC_AUTO, LTS_SRC_BUS, LTS_SRC_TIMER, LTS_SRC_INTERNAL_BUS_ONE, LTS_SRC_INTERNAL_BUS_TWO, LTS_SRC_LAN,
    LTS_SRC_DIO1, LTS_SRC_DIO2, LTS_SRC_DIO3, LTS_SRC_DIO4, LTS_SRC_DIO5, LTS_SRC_DIO6,
    LTS_SRC_DIO7, LTS_SRC_TIN
  } lts_src_t;
  typedef enum logic [2:0] {LTS_OT_INTERNAL_BUS_ONE, LTS_OT_INTERNAL_BUS_TWO, LTS_OT_LAN, LTS_OT_DIO, LTS_OT_TRIGGER_OUT_OUTPUT} lts_oroute_t;
  typedef enum logic [1:0] {LTS_ST_IDLE, LTS_ST_WAIT, LTS_ST_DELAY, LTS_ST_RUN} lts_state_t;

  typedef struct packed {
    logic [16:0] count;
    logic        inf;
    logic        bypass;
    lts_src_t    src;
    logic [36:0] period_us;
    logic [36:0] delay_us;
  } lts_lcfg_t;

  typedef struct packed {
    logic        en;
    lts_oroute_t route;
    logic [2:0]  pin;
  } lts_ocfg_t;

  typedef struct packed {
    logic        we;
    lts_layer_t  layer;
    lts_action_t action;
    lts_lcfg_t   lcfg;
    lts_ocfg_t   ocfg;
  } lts_wr_t;

endpackage : lts_pkg

// File: verification/lts_properties.sv
// Port checker of the layered trigger sequencer
`timescale 1ns/10ps
module lts_properties (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [1:0]  i_initiate,
  input wire logic [1:0]  i_abort,
  input wire logic        i_continuous,
  input wire logic        i_meas_valid,
  input wire logic [6:0]  o_dio_out,
  input wire logic [6:0]  o_dio_oe,
  input wire logic        o_trigger_out_output,
  input wire logic [1:0]  o_act_run,
  input wire logic [1:0]  o_busy,
  input wire logic [16:0] o_buf_count
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // Sequences
  // ****
  // Busy lags state, so a repeated initiate is left out
  sequence s_take;
    i_initiate[0] && !i_abort[0] && !o_busy[0] && !$past(i_initiate[0]);
  endsequence
  sequence s_fill;
    i_meas_valid && !i_initiate[1] && !i_continuous && o_buf_count < 17'h186A0;
  endsequence
  // ****
  // Properties
  // ****
  a_init_busy: assert property (s_take |-> ##2 o_busy[0])
    else $error("busy not raised after initiate");
  a_abort_tran: assert property (i_abort[0] |-> ##2 !o_busy[0])
    else $error("transient busy after abort");
  a_abort_acq: assert property (i_abort[1] |-> ##2 !o_busy[1])
    else $error("acquire busy after abort");
  a_run_pulse: assert property (o_act_run[0] |=> !o_act_run[0])
    else $error("action start longer than one cycle");
  a_run_busy: assert property ((o_act_run & ~o_busy) == 2'h0)
    else $error("action start while idle");
  a_out_pulse: assert property (o_trigger_out_output |=> !o_trigger_out_output)
    else $error("trigger out longer than one cycle");
  a_dio_gate: assert property ((o_dio_out & ~o_dio_oe) == 7'h00)
    else $error("pin pulse without output enable");
  a_buf_fill: assert property (s_fill |=> o_buf_count == $past(o_buf_count) + 17'h00001)
    else $error("one-shot buffer count not advanced");
  a_buf_ring: assert property (i_meas_valid && i_continuous && !i_initiate[1]
    && o_buf_count == 17'h003E8 |=> o_buf_count == 17'h003E8)
    else $error("ring count not saturated");
endmodule : lts_properties

bind lts_sequencer lts_properties lts_properties_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_initiate(i_initiate), .i_abort(i_abort),
  .i_continuous(i_continuous), .i_meas_valid(i_meas_valid), .o_dio_out(o_dio_out),
  .o_dio_oe(o_dio_oe), .o_trigger_out_output(o_trigger_out_output), .o_act_run(o_act_run),
  .o_busy(o_busy), .o_buf_count(o_buf_count));

// File: verification/lts_partner.sv
// Far-side instruments: trigger pins and action completion
`timescale 1ns/10ps
module lts_partner (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_act_run,
  output logic [1:0]      o_act_done,
  output logic [10:0]     o_pins
);
  // Settable so a slow instrument can stretch each action
  int lat = 2;
  initial begin
    o_act_done = 2'h0;
    o_pins = 11'h000;
  end
  task automatic answer(input int a);
    repeat (lat) @(negedge i_clk);
    o_act_done[a] = 1'b1;
    @(negedge i_clk);
    o_act_done[a] = 1'b0;
  endtask : answer
  always @(posedge i_clk) if (i_act_run[0] === 1'b1) fork answer(0); join_none
  always @(posedge i_clk) if (i_act_run[1] === 1'b1) fork answer(1); join_none
  // Rising edge only, as the fixed edge detector looks for
  task automatic hit(input int k);
    @(negedge i_clk);
    o_pins[k] = 1'b1;
    repeat (4) @(negedge i_clk);
    o_pins[k] = 1'b0;
  endtask : hit
endmodule : lts_partner

// File: verification/lts_sequencer_bench.sv
// Self-checking bench of the layered trigger sequencer
`timescale 1ns/10ps
module lts_sequencer_bench;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  lts_pkg::lts_wr_t det_wr = '0;
  lts_pkg::lts_wr_t main_wr = '0;
  logic             cont = 1'b0;
  logic [1:0]       sig [3] = '{2'h0, 2'h0, 2'h0};
  logic             mvalid = 1'b0;
  logic [31:0]      mdata = 32'h0;
  logic [16:0]      raddr = 17'h0;
  logic [1:0]       done, act_run, busy, ibus;
  logic [10:0]      pins;
  logic [6:0]       dio_out, dio_oe;
  logic             trigger_out_output, lan;
  logic [16:0]      buf_count;
  logic [31:0]      rdata;
  int               runs [2];
  int               touts, dios, ibs, lans, failures, checks;
  always #2.5 clk = ~clk;
  lts_sequencer lts_sequencer_inst (.i_clk(clk), .i_rst_n(rst_n), .i_det_wr(det_wr),
    .i_main_wr(main_wr), .i_continuous(cont), .i_initiate(sig[0]), .i_abort(sig[1]),
    .i_bus_trig(sig[2]), .i_act_done(done), .i_internal_bus(pins[9:8]), .i_lan_evt(pins[10]),
    .i_dio_in(pins[6:0]), .i_trigger_in_input(pins[7]), .i_meas_valid(mvalid),
    .i_meas_data(mdata), .i_buf_raddr(raddr), .o_internal_bus(ibus), .o_lan_trig(lan),
    .o_dio_out(dio_out), .o_dio_oe(dio_oe), .o_trigger_out_output(trigger_out_output),
    .o_act_run(act_run), .o_busy(busy), .o_buf_count(buf_count), .o_buf_rdata(rdata));
  lts_partner lts_partner_inst (.i_clk(clk), .i_act_run(act_run), .o_act_done(done), .o_pins(pins));
  always @(posedge clk) begin
    if (act_run[0] === 1'b1) runs[0]++;
    if (act_run[1] === 1'b1) runs[1]++;
    if (trigger_out_output === 1'b1) touts++;
    if (dio_out[4] === 1'b1) dios++;
    if (ibus[0] === 1'b1) ibs++;
    if (lan === 1'b1) lans++;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic lts_pkg::lts_wr_t cf(lts_pkg::lts_action_t a, lts_pkg::lts_src_t s, int n,
    bit byp, bit oen, lts_pkg::lts_oroute_t r);
    cf = '0;
    cf.we = 1'b1;
    cf.layer = lts_pkg::LTS_LY_TRIG;
    cf.action = a;
    cf.lcfg = '{17'(n), 1'b0, byp, s, 37'h0_0000_000A, 37'h0_0000_0000};
    cf.ocfg = '{oen, r, 3'h5};
  endfunction : cf
  task automatic wr(input bit m, input lts_pkg::lts_wr_t w);
    @(negedge clk);
    if (m) main_wr = w;
    else det_wr = w;
    @(negedge clk);
    main_wr = '0;
    det_wr = '0;
  endtask : wr
  // Kinds: 0 initiate, 1 abort, 2 remote-bus trigger
  task automatic kick(input int s, input int a);
    @(negedge clk);
    sig[s][a] = 1'b1;
    @(negedge clk);
    sig[s][a] = 1'b0;
  endtask : kick
  task automatic idle(input int a);
    for (int t = 0; t < 5000 && busy[a] !== 1'b0; t++) @(negedge clk);
    chk(busy[a], 1'b0, "still busy");
  endtask : idle
  task automatic run(input int a, input int n);
    runs = '{0, 0};
    touts = 0;
    kick(0, a);
    repeat (3) @(negedge clk);
    idle(a);
    chk(runs[a], n, "action count");
  endtask : run
  task automatic push(input int n, input logic [31:0] base);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      mvalid = 1'b1;
      mdata = base + 32'(k);
    end
    @(negedge clk);
    mvalid = 1'b0;
  endtask : push
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // ****
  // Scenarios
  // ****
  task automatic t_walk();
    int n;
    runs = '{0, 0};
    kick(0, 0);
    n = 1;
    while (act_run[0] !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n, 5, "walk latency");
    idle(0);
    chk(runs[0], 1, "walk runs");
    chk(touts, 0, "disabled output fired");
  endtask : t_walk
  task automatic t_count();
    lts_partner_inst.lat = 12;
    wr(1, cf(lts_pkg::LTS_AC_ACQ, lts_pkg::LTS_SRC_AUTO, 3, 0, 1, lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT));
    run(1, 3);
    chk(touts, 3, "trigger out count");
    chk(runs[0], 0, "other action ran");
    lts_partner_inst.lat = 2;
  endtask : t_count
  task automatic t_bypass();
    wr(1, cf(lts_pkg::LTS_AC_TRAN, lts_pkg::LTS_SRC_BUS, 2, 1, 0, lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT));
    runs = '{0, 0};
    kick(0, 0);
    repeat (30) @(negedge clk);
    chk(runs[0], 1, "bypassed pass");
    kick(2, 0);
    idle(0);
    chk(runs[0], 2, "bus event pass");
  endtask : t_bypass
  task automatic t_pin();
    wr(1, cf(lts_pkg::LTS_AC_ACQ, lts_pkg::LTS_SRC_DIO3, 1, 0, 1, lts_pkg::LTS_OT_DIO));
    // Enable is registered from the stored setting, one edge after the write
    @(negedge clk);
    chk(dio_oe, 7'h10, "pin enable");
    runs = '{0, 0};
    dios = 0;
    kick(0, 1);
    repeat (30) @(negedge clk);
    chk(runs[1], 0, "ran without pin");
    lts_partner_inst.hit(2);
    idle(1);
    chk(runs[1], 1, "pin event pass");
    chk(dios, 1, "pin output pulse");
  endtask : t_pin
  task automatic t_main();
    wr(1, cf(lts_pkg::LTS_AC_TRAN, lts_pkg::LTS_SRC_AUTO, 2, 0, 0, lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT));
    wr(0, cf(lts_pkg::LTS_AC_TRAN, lts_pkg::LTS_SRC_AUTO, 4, 0, 0, lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT));
    run(0, 2);
  endtask : t_main
  // Continuous auto source paces every layer by the 10 us timer
  task automatic t_auto();
    cont = 1'b1;
    runs = '{0, 0};
    kick(0, 0);
    repeat (3000) @(negedge clk);
    chk(runs[0], 0, "timer period too short");
    idle(0);
    chk(runs[0], 2, "timer-paced passes");
    cont = 1'b0;
  endtask : t_auto
  task automatic t_delay();
    lts_pkg::lts_wr_t w;
    int n;
    w = cf(lts_pkg::LTS_AC_TRAN, lts_pkg::LTS_SRC_AUTO, 1, 0, 1, lts_pkg::LTS_OT_LAN);
    w.layer = lts_pkg::LTS_LY_ARM;
    wr(1, w);
    w.layer = lts_pkg::LTS_LY_TRIG;
    w.ocfg.route = lts_pkg::LTS_OT_INTERNAL_BUS_ONE;
    w.lcfg.delay_us = 37'h0_0000_0005;
    wr(1, w);
    kick(0, 0);
    n = 1;
    while (act_run[0] !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    // At least 5 us beyond the zero-delay walk, at most one tick more
    chk(n >= 1005 && n <= 1205, 1, "trigger delay span");
    idle(0);
    chk(lans, 1, "arm layer output");
    chk(ibs, 1, "trigger layer output");
  endtask : t_delay
  task automatic t_abort();
    lts_pkg::lts_wr_t w;
    int n;
    w = cf(lts_pkg::LTS_AC_ACQ, lts_pkg::LTS_SRC_AUTO, 1, 0, 0, lts_pkg::LTS_OT_TRIGGER_OUT_OUTPUT);
    w.lcfg.inf = 1'b1;
    wr(1, w);
    runs = '{0, 0};
    kick(0, 1);
    repeat (40) @(negedge clk);
    chk(runs[1] > 2, 1, "endless count stalled");
    kick(1, 1);
    repeat (2) @(negedge clk);
    chk(busy[1], 1'b0, "busy after abort");
    n = runs[1];
    repeat (20) @(negedge clk);
    chk(runs[1], n, "ran after abort");
  endtask : t_abort
  task automatic t_buf();
    kick(0, 1);
    kick(1, 1);
    push(5, 32'hA000_0000);
    chk(buf_count, 17'h00005, "one-shot count");
    raddr = 17'h00003;
    @(negedge clk);
    chk(rdata, 32'hA000_0003, "one-shot word");
    cont = 1'b1;
    kick(0, 1);
    kick(1, 1);
    push(1003, 32'hB000_0000);
    chk(buf_count, 17'h003E8, "ring count");
    raddr = 17'h00002;
    @(negedge clk);
    chk(rdata, 32'hB000_03EA, "ring overwrite");
    cont = 1'b0;
  endtask : t_buf
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_walk();
    t_count();
    t_bypass();
    t_pin();
    t_main();
    t_auto();
    t_delay();
    t_abort();
    t_buf();
    final_report();
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule : lts_sequencer_bench
